// File: design/cftm_channel.sv
// test-mode logic of one can fd channel: crc capture, pin routing, filter
//
// Contract
// - with test enable set, last frame crc is readable
// - with test enable clear, both crc fields read zero
// - classical crc sits in a 15-bit field, bits 14:0
// - fd crc sits in a 21-bit field, bits 20:0
// - listen-only drives only recessive bits, no ack or flags; icb_tx_out still follows internal_tx_in while interconnect is active
// - listen-only still accepts data and remote frames
// - self-test filters own frames and stores accepted ones
// - self-test: loopback bit 0 matches all, 1 only own frames
// - self-test overrides mirror when both are enabled
// - self-test 0 sends on pin and receives through transceiver
// - both self-tests acknowledge own frame internally
// - self-test 1 feeds internal transmit back to internal receive
// - self-test 1 ignores receive pin, holds transmit pin recessive
// - interconnect test exchanges frames between channels internally
// - test select 00 means standard test mode
`timescale 1ns/1ps
module cftm_channel
    import cftm_pkg::*;
#(
    parameter int NUM_RULES  = CFTM_NUM_RULES,
    parameter int FIFO_DEPTH = CFTM_FIFO_DEPTH
) (
    input  wire logic                 core_clk_in,
    input  wire logic                 rst_b_in,
    input  wire logic                 comm_test_enable_in,
    input  wire logic [1:0]           comm_test_select_in,
    input  wire logic                 channel_halt_in,
    input  wire logic                 mirror_enable_in,
    input  wire logic                 channel_interconnect_enable_in,
    input  wire logic                 interconnect_test_enable_in,
    input  wire logic                 global_test_in,
    input  wire logic                 internal_tx_in,
    input  wire logic                 core_tx_active_in,
    input  wire logic                 core_ack_slot_in,
    output logic                      internal_rx_out,
    output logic                      tx_pin_out,
    input  wire logic                 rx_pin_in,
    output logic                      icb_tx_out,
    input  wire logic                 icb_rx_in,
    input  wire logic                 crc_done_in,
    input  wire cftm_crc_s            crc_in,
    output logic [CFTM_CLASSIC_CRC_W-1:0] crc_capture_field_out,
    output logic [CFTM_FD_CRC_W-1:0]  fd_crc_capture_out,
    output cftm_mode_e                mode_out,
    output logic                      test_active_out,
    output logic                      icb_active_out,
    input  wire logic                 frame_valid_in,
    input  wire cftm_frame_s          frame_in,
    output logic                      frame_ready_out,
    input  wire logic [NUM_RULES-1:0][CFTM_ID_W-1:0] rule_id_entry_in,
    input  wire logic [NUM_RULES-1:0][CFTM_ID_W-1:0] rule_mask_in,
    input  wire logic [NUM_RULES-1:0] rule_loopback_select_in,
    output logic                      rx_valid_out,
    output cftm_rxent_s               rx_entry_out,
    input  wire logic                 rx_ready_in
);

    logic                       listen;
    logic                       self0;
    logic                       self1;
    logic                       self_test;
    logic                       self_ack;
    logic                       next_tx_pin;
    logic                       next_rx;
    logic                       next_icb_tx;
    logic [NUM_RULES-1:0]       hit;
    logic                       any_hit;
    logic [CFTM_RULE_IDX_W-1:0] hit_idx;
    logic                       push;
    cftm_rxent_s                push_entry;
    logic                       fifo_valid;
    logic                       fifo_pop;
    cftm_rxent_s                fifo_data;

    // select field decode
    function automatic cftm_mode_e decode_mode(input logic [1:0] sel);
        cftm_mode_e m;
        unique case (sel)
            2'b00: m = CFTM_STANDARD;
            2'b01: m = CFTM_LISTEN;
            2'b10: m = CFTM_SELF0;
            2'b11: m = CFTM_SELF1;
        endcase
        return m;
    endfunction

    // lowest-numbered matching rule wins
    function automatic logic [CFTM_RULE_IDX_W-1:0] first_hit(
        input logic [NUM_RULES-1:0] h);
        logic [CFTM_RULE_IDX_W-1:0] idx;
        idx = '0;
        for (int i = NUM_RULES-1; i >= 0; i--) begin
            if (h[i]) begin
                idx = CFTM_RULE_IDX_W'(i);
            end
        end
        return idx;
    endfunction

    // mode settings taken only while the channel is halted
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            test_active_out <= 1'b0;
            mode_out        <= CFTM_STANDARD;
        end else if (channel_halt_in) begin
            test_active_out <= comm_test_enable_in;
            mode_out        <= decode_mode(comm_test_select_in);
        end
    end

    // interconnect enables taken only in global test
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            icb_active_out <= 1'b0;
        end else if (global_test_in) begin
            icb_active_out <= channel_interconnect_enable_in
                              && interconnect_test_enable_in;
        end
    end

    assign listen    = test_active_out && (mode_out == CFTM_LISTEN);
    assign self0     = test_active_out && (mode_out == CFTM_SELF0);
    assign self1     = test_active_out && (mode_out == CFTM_SELF1);
    assign self_test = self0 || self1;
    assign self_ack  = self_test && core_tx_active_in
                       && core_ack_slot_in;

    // pin and loopback routing
    always_comb begin
        next_tx_pin = internal_tx_in;
        next_rx     = rx_pin_in;
        next_icb_tx = CFTM_RECESSIVE;
        if (icb_active_out) begin
            next_tx_pin = CFTM_RECESSIVE;
            next_icb_tx = internal_tx_in;
            next_rx     = icb_rx_in & internal_tx_in;
        end else if (listen) begin
            next_tx_pin = CFTM_RECESSIVE;
        end else if (self1) begin
            next_tx_pin = CFTM_RECESSIVE;
            next_rx     = internal_tx_in;
        end
        if (self_ack) begin
            next_rx = CFTM_DOMINANT;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tx_pin_out      <= CFTM_RECESSIVE;
            internal_rx_out <= CFTM_RECESSIVE;
            icb_tx_out      <= CFTM_RECESSIVE;
        end else begin
            tx_pin_out      <= next_tx_pin;
            internal_rx_out <= next_rx;
            icb_tx_out      <= next_icb_tx;
        end
    end

    // crc capture, forced to zero while testing is off
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            crc_capture_field_out <= CFTM_CLASSIC_RESET;
            fd_crc_capture_out    <= CFTM_FD_RESET;
        end else if (!test_active_out) begin
            crc_capture_field_out <= CFTM_CLASSIC_RESET;
            fd_crc_capture_out    <= CFTM_FD_RESET;
        end else if (crc_done_in) begin
            if (crc_in.fd) begin
                fd_crc_capture_out <= crc_in.crc;
            end else begin
                crc_capture_field_out <=
                    crc_in.crc[CFTM_CLASSIC_CRC_W-1:0];
            end
        end
    end

    // receive rule comparison, one comparator per rule
    generate
        for (genvar r = 0; r < NUM_RULES; r++) begin : g_rule
            logic id_ok;
            logic src_ok;
            assign id_ok = (((frame_in.id ^ rule_id_entry_in[r])
                             & rule_mask_in[r]) == '0);
            // own frames: any rule in self-test, else lb 0 with mirror
            assign src_ok = frame_in.own
                ? (self_test || (mirror_enable_in
                   && !rule_loopback_select_in[r]))
                : !rule_loopback_select_in[r];
            assign hit[r] = id_ok && src_ok;
        end
    endgenerate

    assign any_hit               = |hit;
    assign hit_idx               = first_hit(hit);
    assign push                  = frame_valid_in && frame_ready_out
                                   && any_hit;
    assign push_entry.frame      = frame_in;
    assign push_entry.rule       = hit_idx;

    cftm_fifo #(
        .WIDTH ($bits(cftm_rxent_s)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk_in   (core_clk_in),
        .rst_b_in      (rst_b_in),
        .in_valid_in   (push),
        .in_ready_out  (frame_ready_out),
        .in_data_in    (push_entry),
        .out_valid_out (fifo_valid),
        .out_ready_in  (fifo_pop),
        .out_data_out  (fifo_data)
    );

    // output register stage towards the receive buffers
    assign fifo_pop = fifo_valid && (!rx_valid_out || rx_ready_in);

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rx_valid_out <= 1'b0;
            rx_entry_out <= '0;
        end else begin
            if (fifo_pop) begin
                rx_valid_out <= 1'b1;
                rx_entry_out <= fifo_data;
            end else if (rx_ready_in) begin
                rx_valid_out <= 1'b0;
            end
        end
    end

    // checks
    logic [CFTM_CLASSIC_CRC_W-1:0] crc_low;
    logic [CFTM_FD_CRC_W-1:0]      crc_full;
    logic                          hit_lb;

    assign crc_low  = crc_in.crc[CFTM_CLASSIC_CRC_W-1:0];
    assign crc_full = crc_in.crc;
    assign hit_lb   = rule_loopback_select_in[hit_idx];

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_b_in);

    property p_crc_zero;
        (!test_active_out && !$past(test_active_out))
            |-> (crc_capture_field_out == '0 && fd_crc_capture_out == '0);
    endproperty
    a_crc_zero: assert property (p_crc_zero)
        else $error("crc field nonzero while testing is off");

    property p_crc_classic;
        (test_active_out && crc_done_in && !crc_in.fd)
            |=> (crc_capture_field_out == $past(crc_low));
    endproperty
    a_crc_classic: assert property (p_crc_classic)
        else $error("classical crc not captured");

    property p_crc_fd;
        (test_active_out && crc_done_in && crc_in.fd)
            |=> (fd_crc_capture_out == $past(crc_full))
                && $stable(crc_capture_field_out);
    endproperty
    a_crc_fd: assert property (p_crc_fd)
        else $error("fd crc not captured");

    property p_listen_recessive;
        listen |=> tx_pin_out == CFTM_RECESSIVE;
    endproperty
    a_listen_recessive: assert property (p_listen_recessive)
        else $error("dominant bit driven in listen-only");

    property p_self0_path;
        (self0 && !icb_active_out && !self_ack)
            |=> (tx_pin_out == $past(internal_tx_in))
                && (internal_rx_out == $past(rx_pin_in));
    endproperty
    a_self0_path: assert property (p_self0_path)
        else $error("self-test 0 path broken");

    property p_self1_loop;
        (self1 && !icb_active_out && !self_ack)
            |=> (internal_rx_out == $past(internal_tx_in))
                && tx_pin_out == CFTM_RECESSIVE;
    endproperty
    a_self1_loop: assert property (p_self1_loop)
        else $error("self-test 1 loop broken");

    property p_self_ack;
        (self_test && core_tx_active_in && core_ack_slot_in)
            |=> internal_rx_out == CFTM_DOMINANT;
    endproperty
    a_self_ack: assert property (p_self_ack)
        else $error("own frame not acknowledged");

    property p_icb_path;
        icb_active_out |=> (icb_tx_out == $past(internal_tx_in))
                           && tx_pin_out == CFTM_RECESSIVE;
    endproperty
    a_icb_path: assert property (p_icb_path)
        else $error("interconnect path broken");

    property p_lb_other;
        (push && !frame_in.own) |-> !hit_lb;
    endproperty
    a_lb_other: assert property (p_lb_other)
        else $error("other-node frame matched loopback rule");

    property p_own_needs_mode;
        (frame_valid_in && frame_ready_out && frame_in.own
         && !self_test && !mirror_enable_in) |-> !push;
    endproperty
    a_own_needs_mode: assert property (p_own_needs_mode)
        else $error("own frame stored outside self-test");

    property p_mode_hold;
        !channel_halt_in |=> $stable(mode_out) && $stable(test_active_out);
    endproperty
    a_mode_hold: assert property (p_mode_hold)
        else $error("mode changed outside halt");

    c_self1_own: cover property (self1 && push && frame_in.own);
    c_listen_rx: cover property (listen && push && frame_in.remote);
    c_fd_crc:    cover property (test_active_out && crc_done_in
                                 && crc_in.fd);
    c_fifo_full: cover property (frame_valid_in && !frame_ready_out);

endmodule

// File: design/cftm_fifo.sv
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module cftm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             core_clk_in,
    input  wire logic             rst_b_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wptr;
    logic [AW-1:0]    rptr;
    logic [AW:0]      count;
    logic [AW:0]      next_count;
    logic             push;
    logic             pop;

    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;
    assign out_valid_out = (count != '0);
    assign out_data_out  = mem[rptr];
    assign next_count    = count + (AW+1)'(push) - (AW+1)'(pop);

    always_ff @(posedge core_clk_in) begin
        if (push) begin
            mem[wptr] <= in_data_in;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wptr         <= '0;
            rptr         <= '0;
            count        <= '0;
            in_ready_out <= 1'b0;
        end else begin
            if (push) begin
                wptr <= (wptr == AW'(DEPTH-1)) ? '0 : wptr + AW'(1);
            end
            if (pop) begin
                rptr <= (rptr == AW'(DEPTH-1)) ? '0 : rptr + AW'(1);
            end
            count        <= next_count;
            in_ready_out <= (next_count != (AW+1)'(DEPTH));
        end
    end

endmodule

// File: inc/cftm_pkg.sv
// constants and types shared by the can fd channel test-mode block
package cftm_pkg;

    localparam int CFTM_ID_W          = 29;
    localparam int CFTM_CLASSIC_CRC_W = 15;
    localparam int CFTM_FD_CRC_W      = 21;
    localparam int CFTM_NUM_RULES     = 16;
    localparam int CFTM_RULE_IDX_W    = 4;
    localparam int CFTM_FIFO_DEPTH    = 8;

    localparam logic CFTM_RECESSIVE = 1'b1;
    localparam logic CFTM_DOMINANT  = 1'b0;

    localparam logic [1:0] CFTM_SEL_RESET = 2'h0;
    localparam logic [CFTM_CLASSIC_CRC_W-1:0] CFTM_CLASSIC_RESET = 15'h0000;
    localparam logic [CFTM_FD_CRC_W-1:0]      CFTM_FD_RESET      = 21'h000000;

    typedef enum logic [1:0] {
        CFTM_STANDARD = 2'b00,
        CFTM_LISTEN   = 2'b01,
        CFTM_SELF0    = 2'b10,
        CFTM_SELF1    = 2'b11
    } cftm_mode_e;

    typedef struct packed {
        logic [CFTM_ID_W-1:0] id;
        logic                 ext;
        logic                 remote;
        logic                 fd;
        logic                 own;
    } cftm_frame_s;

    typedef struct packed {
        cftm_frame_s                frame;
        logic [CFTM_RULE_IDX_W-1:0] rule;
    } cftm_rxent_s;

    typedef struct packed {
        logic [CFTM_FD_CRC_W-1:0] crc;
        logic                     fd;
    } cftm_crc_s;

endpackage

// File: sim/cftm_channel_tb.sv
// self-checking bench for the can fd channel test-mode block
`timescale 1ns/1ps
module cftm_channel_tb;
    import cftm_pkg::*;
    logic                          clk, rst_b, en, halt, mir, cie, ite, gt;
    logic                          itx, act, ack, rem, orb, cdone, fv, rxr;
    logic                          rxp, icbr, irx, txp, icbt, ta, ia, frdy;
    logic                          rxv, rx_on, xta, xia;
    logic [1:0]                    sel, xmd;
    cftm_crc_s                     crc;
    cftm_frame_s                   fr;
    cftm_mode_e                    mode;
    cftm_rxent_s                   rxe;
    logic [CFTM_CLASSIC_CRC_W-1:0] ccf, ecm;
    logic [CFTM_FD_CRC_W-1:0]      fdc, efm;
    logic [15:0][CFTM_ID_W-1:0]    rid, rmask;
    logic [15:0]                   rlb;
    cftm_rxent_s                   expq[$];
    int                            fails, n_checks, taken;

    cftm_channel i_dut (
        .core_clk_in(clk), .rst_b_in(rst_b), .comm_test_enable_in(en),
        .comm_test_select_in(sel), .channel_halt_in(halt),
        .mirror_enable_in(mir), .channel_interconnect_enable_in(cie),
        .interconnect_test_enable_in(ite), .global_test_in(gt),
        .internal_tx_in(itx), .core_tx_active_in(act),
        .core_ack_slot_in(ack), .internal_rx_out(irx), .tx_pin_out(txp),
        .rx_pin_in(rxp), .icb_tx_out(icbt), .icb_rx_in(icbr),
        .crc_done_in(cdone), .crc_in(crc), .crc_capture_field_out(ccf),
        .fd_crc_capture_out(fdc), .mode_out(mode), .test_active_out(ta),
        .icb_active_out(ia), .frame_valid_in(fv), .frame_in(fr),
        .frame_ready_out(frdy), .rule_id_entry_in(rid),
        .rule_mask_in(rmask), .rule_loopback_select_in(rlb),
        .rx_valid_out(rxv), .rx_entry_out(rxe), .rx_ready_in(rxr)
    );
    cftm_xcvr_model i_xcvr (
        .tx_pin_in(txp), .remote_bit_in(rem), .rx_pin_out(rxp)
    );
    // second channel on the interconnect wire
    assign icbr = icbt & orb;
    always #4 clk = ~clk;

    task automatic chk(string nm, logic [63:0] exp, logic [63:0] got);
        n_checks++;
        if (exp !== got) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic step();
        @(posedge clk);
        #1;
    endtask

    task automatic set_mode(logic e, logic [1:0] s);
        halt = 1;
        en = e;
        sel = s;
        step();
        halt = 0;
        xta = e;
        xmd = s;
        if (!e)
            {ecm, efm} = '0;
        chk("test_active", e, ta);
        if (e)
            chk("mode", s, mode);
    endtask

    task automatic set_icb(logic c, logic i);
        gt = 1;
        cie = c;
        ite = i;
        step();
        gt = 0;
        xia = c & i;
        chk("icb_active", c & i, ia);
    endtask

    task automatic pins(int n);
        logic etx, erx, eicb;
        repeat (n) begin
            itx = $urandom;
            act = (xta && xmd == CFTM_LISTEN) ? 1'b0 : $urandom;
            ack = $urandom;
            rem = $urandom;
            orb = $urandom;
            mir = $urandom;
            #1;
            etx = (xia || (xta && xmd inside {CFTM_LISTEN, CFTM_SELF1}))
                ? 1'b1 : itx;
            eicb = xia ? itx : 1'b1;
            erx = xia ? (icbr & itx) : (xta && xmd == CFTM_SELF1) ? itx : rxp;
            if (xta && xmd[1] && act && ack)
                erx = 1'b0;
            @(posedge clk);
            #1;
            chk("tx_pin", etx, txp);
            chk("internal_rx", erx, irx);
            chk("icb_tx", eicb, icbt);
        end
    endtask

    task automatic crc_run(int n);
        repeat (n) begin
            crc = 22'($urandom);
            cdone = $urandom;
            if (cdone && xta && crc.fd)
                efm = crc.crc;
            else if (cdone && xta)
                ecm = crc.crc[14:0];
            if (!xta)
                {ecm, efm} = '0;
            step();
            chk("crc_classic", ecm, ccf);
            chk("crc_fd", efm, fdc);
        end
        cdone = 0;
    endtask

    function automatic int hit(cftm_frame_s f);
        for (int i = 0; i < 16; i++)
            if (((f.id ^ rid[i]) & rmask[i]) == 0 &&
                (f.own ? ((xta && xmd[1]) || (mir && !rlb[i])) : !rlb[i]))
                return i;
        return -1;
    endfunction

    function automatic cftm_frame_s rnd_frame(bit own_ok);
        cftm_frame_s f;
        f = 33'({$urandom, $urandom});
        if ($urandom % 2)
            f.id = rid[$urandom % 14];
        f.own = f.own & own_ok;
        return f;
    endfunction

    task automatic send(cftm_frame_s f);
        int h;
        h = hit(f);
        fr = f;
        fv = 1;
        for (int k = 0; k < 50 && !frdy; k++)
            step();
        if (!frdy) begin
            chk("frame_ready", 1, frdy);
            tally_and_finish();
        end
        step();
        if (h >= 0)
            expq.push_back('{f, 4'(h)});
    endtask

    task automatic drain();
        for (int k = 0; k < 300 && expq.size() > 0; k++)
            step();
        chk("rx_pending", 0, expq.size());
        if (expq.size() > 0)
            tally_and_finish();
    endtask

    always @(posedge clk) begin
        if (rxv && rxr) begin
            if (expq.size() == 0)
                chk("rx_extra", 0, 1);
            else
                chk("rx_entry", expq.pop_front(), rxe);
        end
        #1 rxr = rx_on ? $urandom : 1'b0;
    end

    initial begin
        {clk, rst_b, en, halt, mir, cie, ite, gt, itx, act, ack} = '0;
        {rem, orb, cdone, fv, rxr, rx_on, sel, crc, fr, xta, xia, xmd} = '0;
        {rid, rmask, rlb, ecm, efm, fails, n_checks, taken} = '0;
        void'($urandom(36));
        repeat (12) @(posedge clk);
        #1;
        chk("reset_state", {3'h7, 42'h0},
            {txp, irx, icbt, ccf, fdc, mode, ta, ia, frdy, rxv});
        rst_b = 1;
        step();
        chk("ready_after_reset", 1, frdy);
        for (int m = 0; m < 8; m++) begin
            set_mode(m[2], m[1:0]);
            pins(40);
        end
        en = 0;
        sel = 2'h1;
        step();
        chk("mode_hold", 3'h7, {ta, mode});
        set_icb(1, 1);
        pins(40);
        set_icb(0, 1);
        set_mode(1, 2'h0);
        crc_run(40);
        set_mode(1, 2'h2);
        crc_run(20);
        set_mode(0, 2'h0);
        crc_run(20);
        // rule 14 own-only catch-all, rule 15 catch-all for other frames
        for (int i = 0; i < 16; i++) begin
            rid[i] = CFTM_ID_W'($urandom);
            rmask[i] = (i < 14) ? '1 : '0;
        end
        rlb = 16'($urandom);
        rlb[15:14] = 2'b01;
        for (int m = 0; m < 8; m++) begin
            mir = m[2];
            set_mode(1, m[1:0]);
            rx_on = 1;
            repeat (12)
                send(rnd_frame(1));
            fv = 0;
            drain();
        end
        set_mode(1, 2'h3);
        rx_on = 0;
        for (int k = 0; k < 20; k++) begin
            if (frdy) begin
                send(rnd_frame(0));
                taken++;
            end else
                step();
        end
        fv = 0;
        chk("fill_count", 9, taken);
        chk("ready_full", 0, frdy);
        rx_on = 1;
        drain();
        tally_and_finish();
    end
endmodule

// File: sim/cftm_xcvr_model.sv
// transceiver plus remote node model on the can bus
`timescale 1ns/1ps
module cftm_xcvr_model (
    input  wire logic tx_pin_in,
    input  wire logic remote_bit_in,
    output logic      rx_pin_out
);
    // wired-and bus, own bit echoes back through the transceiver
    assign rx_pin_out = tx_pin_in & remote_bit_in;
endmodule
